// >>> rtl/sbc_pkg.sv
package sbc_pkg;
   // axi4-lite byte offsets
   localparam logic [11:0] SBC_ADDR_CTRL     = 12'h000;
   localparam logic [11:0] SBC_ADDR_STATUS   = 12'h004;
   localparam logic [11:0] SBC_ADDR_SETTINGS = 12'h008;
   localparam logic [11:0] SBC_ADDR_RAW      = 12'h00C;
   localparam logic [11:0] SBC_ADDR_STRAPS   = 12'h010;
   localparam logic [11:0] SBC_ADDR_BOOTOPT  = 12'h014;
   // otp byte addresses
   localparam logic [7:0]  SBC_OTP_BYTE0     = 8'h00;
   localparam logic [7:0]  SBC_OTP_BYTE1     = 8'h01;
   // byte 0 fields
   localparam int          SBC_B0_DBG_BLOCK  = 0;
   localparam int          SBC_B0_SECURE_WLD = 1;
   // byte 1 fields
   localparam int          SBC_B1_DEBUG_OFF  = 0;
   localparam int          SBC_B1_AUTH       = 1;
   localparam int          SBC_B1_KEY_LO     = 2;
   localparam int          SBC_B1_KEY_PKG    = 4;
   // strap fields
   localparam int          SBC_ST_REF_LO     = 5;
   localparam int          SBC_ST_REF_HI     = 7;
   localparam int          SBC_ST_SEL_LO     = 8;
   localparam logic [1:0]  SBC_ST_SEL_XTAL   = 2'h3;
   // extended boot option fields
   localparam int          SBC_EB_SECURE     = 17;
   localparam int          SBC_EB_PLL        = 21;
   // reset values
   localparam logic [7:0]  SBC_RST_BYTE      = 8'h00;
   localparam logic [1:0]  SBC_RST_KEY       = 2'h0;
   // settle time before straps are sampled, after reset release
   localparam int          SBC_SETTLE_NS     = 10;
   localparam int          SBC_CLK_NS        = 5;
   localparam int          SBC_SETTLE_CYC    = (SBC_SETTLE_NS + SBC_CLK_NS - 1) / SBC_CLK_NS;
   localparam logic [3:0]  SBC_SETTLE_LAST   = 4'(SBC_SETTLE_CYC - 1);
   // key size codes
   localparam logic [1:0]  SBC_KEY_NA        = 2'h0;
   localparam logic [1:0]  SBC_KEY_1K        = 2'h1;
   localparam logic [1:0]  SBC_KEY_2K        = 2'h2;
   localparam logic [1:0]  SBC_KEY_4K        = 2'h3;
   // reference clock codes
   localparam logic [1:0]  SBC_REF_BAD       = 2'h0;
   localparam logic [1:0]  SBC_REF_24M       = 2'h1;
   localparam logic [1:0]  SBC_REF_48M       = 2'h2;

   typedef enum logic [2:0] {
      SBC_ST_SETTLE,
      SBC_ST_STRAP,
      SBC_ST_REQ0,
      SBC_ST_REQ1,
      SBC_ST_DONE
   } sbc_state_t;
endpackage

// >>> rtl/sbc_secure_boot_config_decode.sv
// Local design decisions: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module sbc_secure_boot_config_decode (
   input  wire logic        clk,
   input  wire logic        rst_b,
   input  wire logic        secure_fuse,
   input  wire logic [10:0] strap_pins,
   input  wire logic [31:0] boot_option,
   output logic [7:0]       otp_addr,
   output logic             otp_req,
   input  wire logic        otp_ack,
   input  wire logic [7:0]  otp_rdata,
   output logic             settings_valid,
   output logic             debug_port_block,
   output logic             secure_world_en,
   output logic             debug_mode_en,
   output logic             boot_auth_req,
   output logic [1:0]       key_size,
   output logic             key_hash_only,
   output logic             secure_boot_en,
   output logic [1:0]       ref_clk_sel,
   output logic             ref_clk_bad,
   output logic             pll_en,
   input  wire logic [31:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [31:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready
);
   import sbc_pkg::*;

   typedef struct packed {
      sbc_state_t  state;
      logic [3:0]  cnt;
      // pin synchronisers
      logic [10:0] strap_s1;
      logic [10:0] strap_s2;
      logic [1:0]  fuse_s;
      // boot inputs and otp bytes, latched once, and the otp request
      logic [10:0] strap_l;
      logic [31:0] bopt_l;
      logic        sec_l;
      logic [7:0]  byte0;
      logic [7:0]  byte1;
      logic [7:0]  otp_addr;
      logic        otp_req;
      // decoded settings
      logic        valid;
      logic        dbg_block;
      logic        sec_world;
      logic        dbg_en;
      logic        auth;
      logic [1:0]  key;
      logic        hash;
      logic        sb_en;
      logic [1:0]  ref_sel;
      logic        ref_bad;
      logic        pll;
      // axi4-lite slave state
      logic        hold;
      logic        aw_got;
      logic        w_got;
      logic        w_ok;
      logic        aw_ctrl;
      logic        w_en;
      logic        w_bit;
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } sbc_regs_t;

   sbc_regs_t q;
   sbc_regs_t d;

   function automatic logic [1:0] ref_decode(input logic [10:0] s);
      // 24/48 MHz only valid with xtal source selected
      if (s[SBC_ST_SEL_LO +: 2] != SBC_ST_SEL_XTAL) begin
         return SBC_REF_BAD;
      end
      if (s[SBC_ST_REF_LO] && s[SBC_ST_REF_HI]) begin
         return SBC_REF_24M;
      end
      if (!s[SBC_ST_REF_LO] && !s[SBC_ST_REF_HI]) begin
         return SBC_REF_48M;
      end
      return SBC_REF_BAD;
   endfunction

   // read data comes from registered state only
   function automatic logic [31:0] rd_mux(input sbc_regs_t r, input logic [11:0] a);
      case (a)
         SBC_ADDR_CTRL:     return {31'h00000000, r.hold};
         SBC_ADDR_STATUS:   return {26'h0000000, r.ref_bad, r.sec_l, r.sb_en, r.pll, r.valid,
                                    r.state == SBC_ST_DONE};
         SBC_ADDR_SETTINGS: return {20'h00000, r.ref_sel, r.sb_en, r.pll, r.hash, r.key, r.auth,
                                    r.dbg_en, r.sec_world, r.dbg_block, r.valid};
         SBC_ADDR_RAW:      return {16'h0000, r.byte1, r.byte0};
         SBC_ADDR_STRAPS:   return {21'h000000, r.strap_l};
         SBC_ADDR_BOOTOPT:  return r.bopt_l;
         default:           return 32'h00000000;
      endcase
   endfunction

   // mapped and word aligned; anything else answers slverr
   function automatic logic addr_ok(input logic [11:0] a);
      return (a <= SBC_ADDR_BOOTOPT) && (a[1:0] == 2'h0);
   endfunction

   always_comb begin
      d = q;
      // two flops before any logic reads a strap or fuse pin; boot_option is sampled directly
      d.strap_s1 = strap_pins;
      d.strap_s2 = q.strap_s1;
      d.fuse_s   = {q.fuse_s[0], secure_fuse};
      case (q.state)
         SBC_ST_SETTLE: begin
            // saturate so a long hold cannot wrap the count
            if (q.cnt != 4'hF) begin
               d.cnt = q.cnt + 4'h1;
            end
            // the hold bit would keep the loader here, but reset clears it and no write can set it before straps are taken
            if (q.cnt >= SBC_SETTLE_LAST && !q.hold) begin
               d.state = SBC_ST_STRAP;
            end
         end
         SBC_ST_STRAP: begin
            d.strap_l = q.strap_s2;
            d.bopt_l  = boot_option;
            d.pll     = boot_option[SBC_EB_PLL];
            d.ref_sel = ref_decode(q.strap_s2);
            d.ref_bad = ref_decode(q.strap_s2) == SBC_REF_BAD;
            d.sec_l   = q.fuse_s[1];
            if (q.fuse_s[1]) begin
               d.otp_addr = SBC_OTP_BYTE0;
               d.otp_req  = 1'b1;
               d.state    = SBC_ST_REQ0;
            end else begin
               d.dbg_en = 1'b1;
               d.sb_en  = boot_option[SBC_EB_SECURE];
               d.valid  = 1'b1;
               d.state  = SBC_ST_DONE;
            end
         end
         SBC_ST_REQ0: begin
            // byte 0 in, byte 1 next
            if (otp_ack) begin
               d.byte0    = otp_rdata;
               d.otp_addr = SBC_OTP_BYTE1;
               d.state    = SBC_ST_REQ1;
            end
         end
         SBC_ST_REQ1: begin
            if (otp_ack) begin
               d.byte1     = otp_rdata;
               d.otp_req   = 1'b0;
               d.dbg_block = q.byte0[SBC_B0_DBG_BLOCK];
               d.sec_world = q.byte0[SBC_B0_SECURE_WLD];
               d.dbg_en    = !otp_rdata[SBC_B1_DEBUG_OFF];
               d.auth      = otp_rdata[SBC_B1_AUTH];
               d.key       = otp_rdata[SBC_B1_KEY_LO +: 2];
               d.hash      = otp_rdata[SBC_B1_KEY_PKG];
               if (otp_rdata[SBC_B1_DEBUG_OFF]) begin
                  d.sb_en = 1'b1;
               end else begin
                  d.sb_en = q.bopt_l[SBC_EB_SECURE];
               end
               d.valid     = 1'b1;
               d.state     = SBC_ST_DONE;
            end
         end
         SBC_ST_DONE: begin
            d.state = SBC_ST_DONE;
         end
         default: begin
            d.state = SBC_ST_SETTLE;
         end
      endcase

      // axi4-lite write: address and data in either order
      d.awready = 1'b0;
      d.wready  = 1'b0;
      if (s_axi_awvalid && q.awready) begin
         d.aw_got  = 1'b1;
         // refused addresses still get a response, as slverr
         d.w_ok    = addr_ok(s_axi_awaddr[11:0]);
         d.aw_ctrl = s_axi_awaddr[11:0] == SBC_ADDR_CTRL;
      end
      if (s_axi_wvalid && q.wready) begin
         d.w_got = 1'b1;
         // only byte lane 0 carries the hold bit
         d.w_en  = s_axi_wstrb[0];
         d.w_bit = s_axi_wdata[0];
      end
      if (!q.aw_got && !q.awready && !q.bvalid && s_axi_awvalid) begin
         d.awready = 1'b1;
      end
      if (!q.w_got && !q.wready && !q.bvalid && s_axi_wvalid) begin
         d.wready = 1'b1;
      end
      if (q.aw_got && q.w_got && !q.bvalid) begin
         d.bvalid = 1'b1;
         d.bresp  = q.w_ok ? 2'h0 : 2'h2;
         d.aw_got = 1'b0;
         d.w_got  = 1'b0;
         // applied once both beats are in, whatever their order
         if (q.aw_ctrl && q.w_en) begin
            d.hold = q.w_bit;
         end
      end
      if (q.bvalid && s_axi_bready) begin
         d.bvalid = 1'b0;
      end

      // axi4-lite read: one at a time, rvalid stands until rready
      d.arready = 1'b0;
      if (!q.arready && !q.rvalid && s_axi_arvalid) begin
         d.arready = 1'b1;
      end
      if (s_axi_arvalid && q.arready) begin
         d.rvalid = 1'b1;
         d.rdata  = rd_mux(q, s_axi_araddr[11:0]);
         d.rresp  = addr_ok(s_axi_araddr[11:0]) ? 2'h0 : 2'h2;
      end
      if (q.rvalid && s_axi_rready) begin
         d.rvalid = 1'b0;
      end
   end

   // async reset clears every field, outputs included
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   // pll bypass and enabled both supported through pll_en
   assign otp_addr         = q.otp_addr;
   assign otp_req          = q.otp_req;
   assign settings_valid   = q.valid;
   assign debug_port_block = q.dbg_block;
   assign secure_world_en  = q.sec_world;
   assign debug_mode_en    = q.dbg_en;
   assign boot_auth_req    = q.auth;
   assign key_size         = q.key;
   assign key_hash_only    = q.hash;
   assign secure_boot_en   = q.sb_en;
   assign ref_clk_sel      = q.ref_sel;
   assign ref_clk_bad      = q.ref_bad;
   assign pll_en           = q.pll;
   assign s_axi_awready    = q.awready;
   assign s_axi_wready     = q.wready;
   assign s_axi_bresp      = q.bresp;
   assign s_axi_bvalid     = q.bvalid;
   assign s_axi_arready    = q.arready;
   assign s_axi_rdata      = q.rdata;
   assign s_axi_rresp      = q.rresp;
   assign s_axi_rvalid     = q.rvalid;
endmodule

// >>> verification/sbc_otp_model.sv
`timescale 1ns/10ps
module sbc_otp_model
   import sbc_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst_b,
   input  wire logic       otp_req,
   input  wire logic [7:0] otp_addr,
   input  wire logic [3:0] lat,
   input  wire logic [7:0] byte0,
   input  wire logic [7:0] byte1,
   output logic            otp_ack,
   output logic [7:0]      otp_rdata
);
   logic [3:0] cnt_q;
   logic [7:0] last_q;
   logic [7:0] word;
   assign word = (otp_addr == SBC_OTP_BYTE0) ? byte0 : byte1;
   assign otp_ack = otp_req && (cnt_q == lat);
   // idle bus shows no stale byte
   assign otp_rdata = otp_ack ? word : ~last_q;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_q <= 4'h0;
         last_q <= 8'h00;
      end else if (otp_ack) begin
         cnt_q <= 4'h0;
         last_q <= word;
      end else begin
         cnt_q <= otp_req ? cnt_q + 4'h1 : 4'h0;
      end
   end
endmodule

// >>> verification/sbc_secure_boot_config_decode_asserts.sv
`timescale 1ns/10ps
module sbc_secure_boot_config_decode_asserts
   import sbc_pkg::*;
(
   input wire logic        clk,
   input wire logic        rst_b,
   input wire logic [10:0] strap_pins,
   input wire logic [31:0] boot_option,
   input wire logic [7:0]  otp_addr,
   input wire logic        otp_req,
   input wire logic        otp_ack,
   input wire logic [7:0]  otp_rdata,
   input wire logic        settings_valid,
   input wire logic        debug_port_block,
   input wire logic        secure_world_en,
   input wire logic        debug_mode_en,
   input wire logic        boot_auth_req,
   input wire logic [1:0]  key_size,
   input wire logic        key_hash_only,
   input wire logic        secure_boot_en,
   input wire logic [1:0]  ref_clk_sel,
   input wire logic        pll_en
);
   logic [7:0] b0_q, b1_q;
   logic       sec_q;
   logic [1:0] ref_e;
   logic [1:0] st;
   assign st = {strap_pins[SBC_ST_REF_HI], strap_pins[SBC_ST_REF_LO]};
   assign ref_e = (strap_pins[9:8] != SBC_ST_SEL_XTAL) ? SBC_REF_BAD :
                  (st == 2'h3) ? SBC_REF_24M : (st == 2'h0) ? SBC_REF_48M : SBC_REF_BAD;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) {b0_q, b1_q, sec_q} <= 17'h0;
      else if (otp_req && otp_ack && otp_addr == SBC_OTP_BYTE0) b0_q <= otp_rdata;
      else if (otp_req && otp_ack) {b1_q, sec_q} <= {otp_rdata, 1'b1};
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   property p_first; $rose(otp_req) |-> otp_addr == SBC_OTP_BYTE0; endproperty
   property p_second; otp_req && otp_ack && otp_addr == SBC_OTP_BYTE0 |=> otp_req && otp_addr == SBC_OTP_BYTE1; endproperty
   property p_apply; otp_req && otp_ack && otp_addr == SBC_OTP_BYTE1 |=> settings_valid && !otp_req; endproperty
   property p_byte0; settings_valid && sec_q |-> debug_port_block == b0_q[0] && secure_world_en == b0_q[1]; endproperty
   property p_byte1;
      settings_valid && sec_q |-> debug_mode_en == !b1_q[0] && boot_auth_req == b1_q[1]
         && key_size == b1_q[3:2] && key_hash_only == b1_q[4];
   endproperty
   property p_hold;
      settings_valid |=> settings_valid && $stable({debug_port_block, secure_world_en, debug_mode_en,
         boot_auth_req, key_size, key_hash_only, secure_boot_en, ref_clk_sel, pll_en});
   endproperty
   property p_pll; $rose(settings_valid) |-> pll_en == boot_option[SBC_EB_PLL]; endproperty
   property p_sboot; $rose(settings_valid) && debug_mode_en |-> secure_boot_en == boot_option[SBC_EB_SECURE]; endproperty
   property p_ref; $rose(settings_valid) |-> ref_clk_sel == ref_e; endproperty
   a_first: assert property (p_first) else $error("fetch did not start at byte 0");
   a_second: assert property (p_second) else $error("second byte not requested");
   a_apply: assert property (p_apply) else $error("settings not applied after fetch");
   a_byte0: assert property (p_byte0) else $error("byte 0 decode wrong");
   a_byte1: assert property (p_byte1) else $error("byte 1 decode wrong");
   a_hold: assert property (p_hold) else $error("settings changed after latch");
   a_pll: assert property (p_pll) else $error("pll select wrong");
   a_sboot: assert property (p_sboot) else $error("secure boot select wrong");
   a_ref: assert property (p_ref) else $error("reference clock decode wrong");
   c_dbg_on: cover property (settings_valid && sec_q && debug_mode_en);
   c_dbg_off: cover property (settings_valid && sec_q && !debug_mode_en);
   c_plain: cover property ($rose(settings_valid) && !sec_q);
endmodule
bind sbc_secure_boot_config_decode sbc_secure_boot_config_decode_asserts i_chk (.clk, .rst_b, .strap_pins,
   .boot_option, .otp_addr, .otp_req, .otp_ack, .otp_rdata, .settings_valid, .debug_port_block, .secure_world_en,
   .debug_mode_en, .boot_auth_req, .key_size, .key_hash_only, .secure_boot_en, .ref_clk_sel, .pll_en);

// >>> verification/sbc_secure_boot_config_decode_tb_top.sv
`timescale 1ns/10ps
module sbc_secure_boot_config_decode_tb_top;
   import sbc_pkg::*;
`define CHK(nm, e, a) begin n_tests++; if ((a) !== (e)) begin errors++; $display("mismatch %s %0h %0h", nm, e, a); end end
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic secure_fuse, otp_req, otp_ack, settings_valid, debug_port_block, secure_world_en, debug_mode_en;
   logic boot_auth_req, key_hash_only, secure_boot_en, ref_clk_bad, pll_en;
   logic [1:0] key_size, ref_clk_sel, s_axi_bresp, s_axi_rresp;
   logic [7:0] otp_addr, otp_rdata, byte0, byte1;
   logic [10:0] strap_pins;
   logic [31:0] boot_option, s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
   logic [3:0] s_axi_wstrb, lat;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   int errors = 0;
   int n_tests = 0;
   logic        tfu [5] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
   logic [7:0]  tb0 [5] = '{8'h01, 8'h02, 8'h03, 8'h00, 8'h00};
   logic [7:0]  tb1 [5] = '{8'h12, 8'h05, 8'h09, 8'h0C, 8'h0C};
   logic [10:0] tst [5] = '{11'h3A0, 11'h300, 11'h1A0, 11'h3A0, 11'h300};
   logic [1:0]  tbo [5] = '{2'h3, 2'h0, 2'h2, 2'h0, 2'h1};
   sbc_secure_boot_config_decode i_dut (.clk, .rst_b, .secure_fuse, .strap_pins, .boot_option, .otp_addr, .otp_req,
      .otp_ack, .otp_rdata, .settings_valid, .debug_port_block, .secure_world_en, .debug_mode_en, .boot_auth_req,
      .key_size, .key_hash_only, .secure_boot_en, .ref_clk_sel, .ref_clk_bad, .pll_en, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready);
   sbc_otp_model i_otp (.clk, .rst_b, .otp_req, .otp_addr, .lat, .byte0, .byte1, .otp_ack, .otp_rdata);
   always #2.5 clk = ~clk;
   task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'hF;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic axi_rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   task automatic complete_run;
      $display("errors %0d comparisons %0d", errors, n_tests);
      if (errors == 0 && n_tests > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      errors++;
      complete_run();
   end
   initial begin
      logic [31:0] d;
      logic [1:0]  r, ref_e;
      logic        dbg;
      logic        sb;
      logic [31:0] exp_w;
      int          k;
      {secure_fuse, byte0, byte1, strap_pins, boot_option, lat} = '0;
      {s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_wstrb} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      for (int i = 0; i < 5; i++) begin
         @(posedge clk);
         rst_b <= 1'b0;
         secure_fuse <= tfu[i];
         byte0 <= tb0[i];
         byte1 <= tb1[i];
         strap_pins <= tst[i];
         boot_option <= {10'h0, tbo[i][1], 3'h0, tbo[i][0], 17'h0};
         lat <= 4'(i);
         repeat (12) @(posedge clk);
         rst_b <= 1'b1;
         k = 0;
         while (!settings_valid && k < 200) begin
            @(posedge clk);
            k++;
         end
         #1;
         dbg = tfu[i] ? !tb1[i][0] : 1'b1;
         ref_e = (tst[i][9:8] != SBC_ST_SEL_XTAL) ? SBC_REF_BAD : (tst[i][7] && tst[i][5]) ? SBC_REF_24M :
                 (!tst[i][7] && !tst[i][5]) ? SBC_REF_48M : SBC_REF_BAD;
         `CHK("valid", 1'b1, settings_valid)
         if (tfu[i]) begin
            `CHK("dbgblk", tb0[i][0], debug_port_block)
            `CHK("secworld", tb0[i][1], secure_world_en)
            `CHK("auth", tb1[i][1], boot_auth_req)
            `CHK("key", tb1[i][3:2], key_size)
            `CHK("hash", tb1[i][4], key_hash_only)
            axi_rd({20'h0, SBC_ADDR_RAW}, d, r);
            `CHK("raw", {16'h0, tb1[i], tb0[i]}, d)
         end
         `CHK("dbgmode", dbg, debug_mode_en)
         `CHK("sboot", dbg ? tbo[i][0] : 1'b1, secure_boot_en)
         `CHK("pll", tbo[i][1], pll_en)
         `CHK("ref", ref_e, ref_clk_sel)
         `CHK("refbad", ref_e == SBC_REF_BAD, ref_clk_bad)
         sb = dbg ? tbo[i][0] : 1'b1;
         exp_w = {20'h0, ref_e, sb, tbo[i][1], tfu[i] & tb1[i][4], (tfu[i] ? tb1[i][3:2] : 2'h0),
                  tfu[i] & tb1[i][1], dbg, tfu[i] & tb0[i][1], tfu[i] & tb0[i][0], 1'b1};
         axi_rd({20'h0, SBC_ADDR_SETTINGS}, d, r);
         `CHK("settings", exp_w, d)
         axi_rd({20'h0, SBC_ADDR_BOOTOPT}, d, r);
         `CHK("bootopt", {10'h0, tbo[i][1], 3'h0, tbo[i][0], 17'h0}, d)
         axi_rd({20'h0, SBC_ADDR_STRAPS}, d, r);
         `CHK("straps", {21'h0, tst[i]}, d)
         @(posedge clk);
         boot_option <= ~boot_option;
         strap_pins <= ~strap_pins;
         repeat (10) @(posedge clk);
         #1;
         `CHK("pll_hold", tbo[i][1], pll_en)
         `CHK("ref_hold", ref_e, ref_clk_sel)
      end
      axi_rd(32'h0000_0040, d, r);
      `CHK("rd_unmapped", 2'h2, r)
      axi_wr({20'h0, SBC_ADDR_CTRL}, 32'h1, r);
      `CHK("wr_ctrl", 2'h0, r)
      axi_rd({20'h0, SBC_ADDR_CTRL}, d, r);
      `CHK("ctrl_set", 32'h1, d)
      axi_wr({20'h0, SBC_ADDR_STATUS}, 32'h0, r);
      `CHK("wr_status", 2'h0, r)
      axi_rd({20'h0, SBC_ADDR_CTRL}, d, r);
      `CHK("ctrl_keep", 32'h1, d)
      axi_wr({20'h0, SBC_ADDR_CTRL}, 32'h0, r);
      axi_rd({20'h0, SBC_ADDR_CTRL}, d, r);
      `CHK("ctrl_clear", 32'h0, d)
      axi_wr(32'h0000_0044, 32'h1, r);
      `CHK("wr_unmapped", 2'h2, r)
      axi_rd({20'h0, SBC_ADDR_CTRL}, d, r);
      `CHK("ctrl_refused", 32'h0, d)
      complete_run();
   end
endmodule
